//--- instr_word_decoder_pkg.sv
// Purpose: shared constants and types for the instruction word decoder
// Assumes: 16-bit program words, four oscillator periods per cycle
// Notes: opcode class and cycle figures used by core and datapath
package instr_word_decoder_pkg;
	localparam int WORD_W = 16;
	localparam int PHASES_PER_CYCLE = 4;
	localparam int STD_INSTR_COUNT = 75;
	localparam int EXT_INSTR_COUNT = 8;
	localparam int TWO_WORD_COUNT = 4;
	localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	// field positions
	localparam int F_LSB = 0;
	localparam int F_MSB = 7;
	localparam int A_POS = 8;
	localparam int D_POS = 9;
	localparam int B_LSB = 9;
	localparam int B_MSB = 11;
	localparam int S_POS = 0;
	localparam int M_LSB = 0;
	localparam int M_MSB = 1;
	localparam int PTR_LSB = 4;
	localparam int PTR_MSB = 5;
	localparam int N_LSB = 0;
	localparam int N_MSB = 10;
	typedef enum logic [2:0]
	{
		CLASS_NOP = 3'h0,
		CLASS_BYTE = 3'h1,
		CLASS_BIT = 3'h2,
		CLASS_LITERAL = 3'h3,
		CLASS_CONTROL = 3'h4
	} op_class_type;
	typedef enum logic [1:0]
	{
		SEQ_FIRST = 2'h0,
		SEQ_SECOND = 2'h1,
		SEQ_DEAD = 2'h3
	} seq_state_type;
endpackage : instr_word_decoder_pkg

//--- instr_word_decoder.sv
// Purpose: split program words into class and operand fields, sequence
//          single, dual and dead instruction cycles
// Assumes: a new word is offered at phase 0 of each instruction cycle
// Notes: decoded fields change only at the first phase of a cycle
`timescale 1ns/1ns

// Summary of operation
// - accepts 75 core plus 8 extended instructions
// - one word mostly; four take two words
// - word splits into opcode and operand fields
// - classes: byte, bit, literal, control
// - byte ops carry file, destination, access fields
// - destination zero: working register; one: file
// - bit ops carry file, bit number, access
// - literal ops: value, pointer select, or none
// - control ops: address, call mode, table mode
// - second word begins with four ones
// - lone second word executes as no-operation
// - plain single word takes one cycle
// - taken test or branch adds dead cycle
// - two-word instructions take two cycles
// - instruction cycle is four oscillator periods
module instr_word_decoder
	import instr_word_decoder_pkg::*;
#(
	parameter int PHASES = PHASES_PER_CYCLE
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] prog_word,
	input wire logic skip_or_branch,
	output logic [1:0] osc_phase,
	output logic cycle_start,
	output op_class_type op_class,
	output logic [15:0] op_word,
	output logic [7:0] file_sel,
	output logic dest_to_file,
	output logic access_sel,
	output logic [2:0] bit_sel,
	output logic [7:0] literal_value,
	output logic [1:0] pointer_sel,
	output logic [10:0] branch_offset,
	output logic fast_mode,
	output logic [1:0] table_mode,
	output logic two_word,
	output logic second_half,
	output logic dead_cycle,
	output logic [1:0] cycle_count
);
	initial
	begin
		if (PHASES != PHASES_PER_CYCLE)
			$error("phase counter only serves four phases");
	end

	seq_state_type state;
	seq_state_type next_state;
	logic [1:0] phase;
	logic [15:0] word;
	op_class_type next_class;
	logic next_two_word;

	wire [3:0] top = prog_word[15:12];
	wire is_tail = (top == SECOND_WORD_TAG);
	// the four two-word opcodes: movff, call, lfsr, goto
	wire is_movff = (top == 4'hc);
	wire is_call_goto = (prog_word[15:9] == 7'h76) ||
		(prog_word[15:8] == 8'hef);
	wire is_lfsr = (prog_word[15:6] == 10'h3b8);
	wire first_two = is_movff || is_call_goto || is_lfsr;
	wire is_bit = (top >= 4'h7) && (top <= 4'hb);
	wire is_lit = (prog_word[15:12] == 4'h0) && (prog_word[11:8] != 4'h0)
		|| is_lfsr;
	wire is_ctrl = (top == 4'hd) || (top == 4'he) ||
		(prog_word[15:8] == 8'h00);
	wire start = (phase == PHASE_RESET);
	// a taken test or branch flushes the word fetched at that same edge
	wire flush = start && skip_or_branch && (state == SEQ_FIRST);
	wire take_new = start && !flush && (state != SEQ_SECOND);

	// opcode selects class; lone tails are nops
	always_comb
	begin
		next_class = CLASS_BYTE;
		if (prog_word == NOP_WORD || is_tail)
			next_class = CLASS_NOP;
		else if (is_bit)
			next_class = CLASS_BIT;
		else if (is_lit)
			next_class = CLASS_LITERAL;
		else if (is_ctrl)
			next_class = CLASS_CONTROL;
		next_two_word = first_two && !is_tail;
	end

	always_comb
	begin
		next_state = state;
		case (state)
			SEQ_FIRST:
				next_state = skip_or_branch ? SEQ_DEAD :
					(next_two_word ? SEQ_SECOND : SEQ_FIRST);
			// a skip cannot end the first half of a pair, so it is ignored
			SEQ_SECOND:
				next_state = SEQ_FIRST;
			SEQ_DEAD:
				next_state = next_two_word ? SEQ_SECOND : SEQ_FIRST;
			default:
				next_state = SEQ_FIRST;
		endcase
	end

	// four oscillator periods form one instruction cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			phase <= PHASE_RESET;
		else
			phase <= phase + 2'h1;
	end

	// latch once per cycle so the datapath sees stable fields
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= SEQ_FIRST;
			word <= NOP_WORD;
			op_class <= CLASS_NOP;
			two_word <= 1'b0;
		end
		else if (start)
		begin
			state <= next_state;
			if (flush)
			begin
				word <= NOP_WORD;
				op_class <= CLASS_NOP;
				two_word <= 1'b0;
			end
			else if (state == SEQ_SECOND)
				word <= prog_word;
			else
			begin
				word <= prog_word;
				op_class <= next_class;
				two_word <= next_two_word;
			end
		end
	end

	assign osc_phase = phase;
	assign cycle_start = start;
	assign op_word = word;
	assign file_sel = word[F_MSB:F_LSB];
	assign dest_to_file = word[D_POS];
	assign access_sel = word[A_POS];
	assign bit_sel = word[B_MSB:B_LSB];
	assign literal_value = word[F_MSB:F_LSB];
	assign pointer_sel = word[PTR_MSB:PTR_LSB];
	assign branch_offset = word[N_MSB:N_LSB];
	assign fast_mode = word[S_POS];
	assign table_mode = word[M_MSB:M_LSB];
	assign second_half = (state == SEQ_SECOND);
	assign dead_cycle = (op_class == CLASS_NOP) && (word == NOP_WORD);
	assign cycle_count = (two_word || state == SEQ_DEAD) ? 2'h2 : 2'h1;

	counter_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		phase == PHASE_LAST |=> phase == PHASE_RESET)
		else $error("cycle not four periods");
	stable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!start |=> $stable(op_word))
		else $error("fields changed mid cycle");
	tail_nop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start && state == SEQ_FIRST && is_tail |=> op_class == CLASS_NOP)
		else $error("lone tail not nop");
	two_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take_new && first_two |=> state == SEQ_SECOND)
		else $error("two-word not two cycles");
	dead_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start && state == SEQ_FIRST && skip_or_branch
		|=> state == SEQ_DEAD && op_class == CLASS_NOP
		##4 state != SEQ_DEAD)
		else $error("dead cycle missing");
	single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		start && state == SEQ_FIRST && !first_two && !skip_or_branch
		|=> state == SEQ_FIRST)
		else $error("single word took extra cycle");
	bit_class_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		take_new && is_bit && prog_word != NOP_WORD
		|=> op_class == CLASS_BIT)
		else $error("bit op misclassed");
	dest_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dest_to_file == op_word[D_POS])
		else $error("destination field wrong");

	cover property (@(posedge sys_clk) state == SEQ_SECOND);
	cover property (@(posedge sys_clk) state == SEQ_DEAD);
	cover property (@(posedge sys_clk) op_class == CLASS_CONTROL);
endmodule : instr_word_decoder

//--- prog_mem_model.sv
// Purpose: program memory stand-in feeding one word per instruction cycle
// Assumes: the decoder samples prog_word at the edge that ends phase 0
// Notes: outside the fetch slot the bus shows a changing pattern
`timescale 1ns/1ns
module prog_mem_model
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cycle_start,
	input wire logic [15:0] offer_word,
	output logic [15:0] prog_word
);
	logic [15:0] churn;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			churn <= 16'h5a5a;
		else
			churn <= churn + 16'h1357;
	end
	// a stale word would hide a decoder that samples in the wrong phase
	assign prog_word = cycle_start ? offer_word : (~offer_word ^ churn);
endmodule : prog_mem_model

//--- tb_instr_word_decoder.sv
// Purpose: self-checking bench for the instruction word decoder
// Assumes: inputs change 5 ns after each rising edge
// Notes: random words avoid the top nibbles c to f, whose class is open
`timescale 1ns/1ns
module tb_instr_word_decoder
	import instr_word_decoder_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic skip_or_branch = 1'b0;
	logic [15:0] offer_word = 16'h0000;
	logic [15:0] prog_word;
	logic [1:0] osc_phase, table_mode, pointer_sel, cycle_count;
	logic cycle_start, dest_to_file, access_sel, fast_mode;
	logic two_word, second_half, dead_cycle;
	op_class_type op_class;
	logic [15:0] op_word;
	logic [7:0] file_sel, literal_value;
	logic [2:0] bit_sel;
	logic [10:0] branch_offset;
	logic [31:0] seed = 32'he1368b5d;
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;
	always #25 sys_clk = ~sys_clk;
	prog_mem_model u_prog_mem_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.cycle_start(cycle_start), .offer_word(offer_word),
		.prog_word(prog_word));
	instr_word_decoder u_instr_word_decoder (.sys_clk(sys_clk),
		.rst_n(rst_n), .prog_word(prog_word),
		.skip_or_branch(skip_or_branch), .osc_phase(osc_phase),
		.cycle_start(cycle_start), .op_class(op_class), .op_word(op_word),
		.file_sel(file_sel), .dest_to_file(dest_to_file),
		.access_sel(access_sel), .bit_sel(bit_sel),
		.literal_value(literal_value), .pointer_sel(pointer_sel),
		.branch_offset(branch_offset), .fast_mode(fast_mode),
		.table_mode(table_mode), .two_word(two_word),
		.second_half(second_half), .dead_cycle(dead_cycle),
		.cycle_count(cycle_count));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [15:0] fld(input logic [15:0] w, int lo, int hi);
		return (w >> lo) & ((16'h1 << (hi - lo + 1)) - 16'h1);
	endfunction : fld
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string name, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", name, e, g);
			bad_count++;
		end
	endtask : chk
	// offer one word in the fetch slot and ride out its four phases
	task automatic run_word(input logic [15:0] w, input logic sob);
		logic [15:0] held;
		offer_word = w;
		skip_or_branch = sob;
		@(posedge sys_clk);
		#5;
		skip_or_branch = 1'b0;
		held = op_word;
		for (int p = 1; p < 4; p++)
		begin
			chk("osc_phase", 16'(p), 16'(osc_phase));
			@(posedge sys_clk);
			#5;
			chk("op_word", held, op_word);
		end
		chk("cycle_start", 16'h1, 16'(cycle_start));
	endtask : run_word
	task automatic chk_fields(input logic [15:0] w);
		chk("op_word", w, op_word);
		chk("file_sel", fld(w, F_LSB, F_MSB), 16'(file_sel));
		chk("dest", fld(w, D_POS, D_POS), 16'(dest_to_file));
		chk("access", fld(w, A_POS, A_POS), 16'(access_sel));
		chk("bit_sel", fld(w, B_LSB, B_MSB), 16'(bit_sel));
		chk("literal", fld(w, 0, 7), 16'(literal_value));
		chk("cycles", 16'h1, 16'(cycle_count));
		chk("dead", 16'h0, 16'(dead_cycle));
	endtask : chk_fields
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles > 3000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	initial
	begin
		logic [15:0] w;
		repeat (4) @(posedge sys_clk);
		#5;
		chk("reset class", 16'(CLASS_NOP), 16'(op_class));
		chk("reset phase", 16'h0, 16'(osc_phase));
		rst_n = 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			seed = lfsr(seed);
			w = {4'(seed[19:16] % 12), seed[11:0]};
			run_word(w, 1'b0);
			chk_fields(w);
		end
		run_word(16'hc012, 1'b0);
		chk("two_word", 16'h1, 16'(two_word));
		chk("pair cycles", 16'h2, 16'(cycle_count));
		chk("first half", 16'h1, 16'(second_half));
		run_word(16'hf345, 1'b0);
		chk("tail word", 16'hf345, op_word);
		chk("tail half", 16'h0, 16'(second_half));
		chk("tail cycles", 16'h2, 16'(cycle_count));
		run_word(16'h2a7c, 1'b0);
		chk_fields(16'h2a7c);
		run_word(NOP_WORD, 1'b0);
		run_word(16'hf0a5, 1'b0);
		chk("lone tail", 16'(CLASS_NOP), 16'(op_class));
		run_word(16'h1b33, 1'b0);
		run_word(16'h0e61, 1'b1);
		chk("dead", 16'h1, 16'(dead_cycle));
		chk("dead class", 16'(CLASS_NOP), 16'(op_class));
		chk("dead cycles", 16'h2, 16'(cycle_count));
		run_word(16'h5d0f, 1'b0);
		chk_fields(16'h5d0f);
		report_and_stop();
	end
endmodule : tb_instr_word_decoder
